//--- verification/ivpm_cpu_model.sv
// CPU core model that takes vectored entries from the interrupt map
`timescale 1ns/1ps
`default_nettype none
module ivpm_cpu_model
  import ivpm_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic entry_req,
  input wire ivpm_entry_t entry,
  input wire logic [3:0] ack_wait, // Cycles of offer before acknowledging
  output logic entry_ack,
  output logic taken, // One-cycle pulse after an accepted entry
  output ivpm_entry_t got // Entry captured at the acknowledge edge
);
  logic [3:0] cnt_q; // Cycles the current offer has stood

  // ------------------------------------------------------------------------
  // Acknowledge after a programmable wait; ack drops on the next edge, a one-cycle pulse
  // ------------------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      entry_ack <= 1'b0;
      taken <= 1'b0;
      got <= '0;
      cnt_q <= 4'h0;
    end else begin
      taken <= entry_ack & entry_req;
      // Take what the offer carries at the same edge as the handshake
      if (entry_ack & entry_req) begin
        got <= entry;
      end
      if (entry_ack) begin
        entry_ack <= 1'b0;
        cnt_q <= 4'h0;
      end else if (entry_req && cnt_q == ack_wait) begin
        entry_ack <= 1'b1;
      end else if (entry_req) begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end
endmodule : ivpm_cpu_model
`default_nettype wire

//--- verification/ivpm_tb.sv
// Self-checking testbench for the interrupt vector and priority map
`timescale 1ns/1ps
`default_nettype none
module testbench
  import ivpm_pkg::*;
();
  logic clock, rst_b, wa_rst, wb_rst, wa_ovf, wa_nmi, wb_ovf, wb_nmi, nmi_pin;
  logic [7:0] pins, pins_fall;
  logic trap_req, ill_trap, dbg_trap, int_en, entry_req, entry_ack, taken, ev7;
  logic [4:0] trap_num;
  logic [3:0] t16, cpu_lvl, ack_wait;
  logic [1:0] t8, csi;
  logic [2:0] uart;
  ivpm_int_ctrl_t [IVPM_NUM_MASKABLE-1:0] ctrl;
  ivpm_entry_t entry, got;
  int err_total = 0;
  int check_count = 0;
  int ev7_cnt = 0;
  logic [15:0] nm_code [7] = '{16'h0000, 16'h0000, 16'h0010, 16'h0020, 16'h0030, 16'h0060, 16'h0060};

  ivpm_core uut (.clock(clock), .rst_b(rst_b), .wdog_a_reset_req(wa_rst), .wdog_b_reset_req(wb_rst),
    .wdog_a_overflow(wa_ovf), .wdog_a_nmi_mode(wa_nmi), .wdog_b_overflow(wb_ovf), .wdog_b_nmi_mode(wb_nmi),
    .nmi_pin(nmi_pin), .ext_edge_pin(pins), .ext_edge_fall(pins_fall), .soft_trap_req(trap_req),
    .soft_trap_num(trap_num), .illegal_opcode_trap(ill_trap), .debug_trap(dbg_trap), .timer16_match_req(t16),
    .timer8_match_req(t8), .csi_done_req(csi), .uart_a_rx_error_req(uart[0]), .uart_a_rx_done_req(uart[1]),
    .uart_a_tx_done_req(uart[2]), .src_int_ctrl(ctrl), .int_enable(int_en), .cpu_level(cpu_lvl),
    .entry_req(entry_req), .entry(entry), .entry_ack(entry_ack), .ext_edge_7_event(ev7));
  ivpm_cpu_model core (.clock(clock), .rst_b(rst_b), .entry_req(entry_req), .entry(entry),
    .ack_wait(ack_wait), .entry_ack(entry_ack), .taken(taken), .got(got));

  // ------------------------------------------------------------------------
  // Clock, time-zero values and the pin seven event counter
  // ------------------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    {rst_b, wa_rst, wb_rst, wa_ovf, wa_nmi, wb_ovf, wb_nmi, nmi_pin, trap_req, ill_trap, dbg_trap} = '0;
    {pins, pins_fall, trap_num, t16, t8, csi, uart, ctrl} = '0;
    int_en = 1'b1;
    cpu_lvl = 4'h8; // Core serving nothing, every level eligible
    ack_wait = 4'h0;
  end
  always @(posedge clock) if (ev7 === 1'b1) ev7_cnt++;

  // ------------------------------------------------------------------------
  // Comparison and closing tasks
  // ------------------------------------------------------------------------
  task automatic check(input ivpm_entry_t exp, input ivpm_entry_t act);
    check_count++;
    if (act !== exp) begin
      err_total++;
      $display("unexpected at %0t: expected %h got %h", $time, exp, act);
    end
  endtask : check
  task automatic stop_test;
    if (err_total == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test

  // Waits for one accepted entry; the offer must stand unchanged until taken
  task automatic expect_entry(input logic [15:0] code, input logic [31:0] handler, input logic save);
    ivpm_entry_t exp;
    int n;
    exp.code = code;
    exp.handler = handler;
    exp.save_next = save;
    n = 0;
    // Let the previous entry's taken pulse settle before looking at it
    #1;
    while (taken !== 1'b1 && n < 60) begin
      @(posedge clock);
      #1;
      n++;
      if (entry_req === 1'b1 && taken !== 1'b1) check(exp, entry);
    end
    if (taken !== 1'b1) begin
      err_total++;
      $display("unexpected at %0t: expected %h got %h", $time, 1'b1, taken);
    end
    check(exp, got);
    @(posedge clock);
  endtask : expect_entry

  // No offer may appear for a span of cycles
  task automatic idle_check(input int n);
    repeat (n) begin
      @(posedge clock);
      #1;
      check_count++;
      if (entry_req !== 1'b0) begin
        err_total++;
        $display("unexpected at %0t: expected %h got %h", $time, 1'b0, entry_req);
      end
    end
  endtask : idle_check

  // ------------------------------------------------------------------------
  // Stimulus tasks: one-cycle pulses, pins included
  // ------------------------------------------------------------------------
  task automatic fire(input logic [18:0] v);
    @(posedge clock);
    wa_ovf <= v[0];
    wa_nmi <= 1'b0;
    pins[6:0] <= v[7:1];
    {uart, csi, t8, t16} <= v[18:8];
    @(posedge clock);
    wa_ovf <= 1'b0;
    pins[6:0] <= 7'h00;
    {uart, csi, t8, t16} <= '0;
  endtask : fire
  task automatic non_mask(input int k);
    @(posedge clock);
    case (k)
      0: wa_rst <= 1'b1;
      1: wb_rst <= 1'b1;
      2: nmi_pin <= 1'b1;
      3: {wa_ovf, wa_nmi} <= 2'h3;
      4: {wb_ovf, wb_nmi} <= 2'h3;
      5: ill_trap <= 1'b1;
      default: dbg_trap <= 1'b1;
    endcase
    @(posedge clock);
    {wa_rst, wb_rst, nmi_pin, wa_ovf, wb_ovf, ill_trap, dbg_trap} <= '0;
  endtask : non_mask
  task automatic trap(input logic [4:0] num);
    @(posedge clock);
    trap_req <= 1'b1;
    trap_num <= num;
    @(posedge clock);
    trap_req <= 1'b0;
  endtask : trap

  // ------------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------------
  initial begin
    logic [15:0] c;
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    expect_entry(16'h0000, 32'h0000_0000, 1'b0);
    for (int k = 0; k < 7; k++) begin
      non_mask(k);
      expect_entry(nm_code[k], {16'h0000, nm_code[k]}, k > 1);
    end
    // Both trap groups with a varying, sometimes slow, acknowledge
    for (int t = 0; t < 32; t++) begin
      ack_wait <= 4'(t % 7);
      trap(5'(t));
      c = 16'h0040 + 16'(t);
      expect_entry(c, {16'h0000, c & 16'hfff0}, 1'b1);
    end
    ack_wait <= 4'h1;
    for (int i = 0; i < 19; i++) begin
      fire(19'h1 << i);
      c = 16'h0080 + 16'(i) * 16'h0010;
      expect_entry(c, {16'h0000, c}, 1'b1);
    end
    // Same cycle, same level: default priority 8 beats 18
    fire(19'h40100);
    expect_entry(16'h0100, 32'h0000_0100, 1'b1);
    expect_entry(16'h01a0, 32'h0000_01a0, 1'b1);
    // A more urgent programmed level beats a lower default priority
    ctrl[8].level <= 3'h2;
    fire(19'h40100);
    expect_entry(16'h01a0, 32'h0000_01a0, 1'b1);
    expect_entry(16'h0100, 32'h0000_0100, 1'b1);
    ctrl[8].level <= 3'h0;
    // Source mask and global enable both hold a request back until lifted
    ctrl[12].mask <= 1'b1;
    fire(19'h01000);
    idle_check(10);
    ctrl[12].mask <= 1'b0;
    expect_entry(16'h0140, 32'h0000_0140, 1'b1);
    int_en <= 1'b0;
    fire(19'h02000);
    idle_check(10);
    int_en <= 1'b1;
    expect_entry(16'h0150, 32'h0000_0150, 1'b1);
    // Eighth pin: rising then falling edge selection
    ev7_cnt = 0;
    @(posedge clock) pins[7] <= 1'b1;
    repeat (3) @(posedge clock);
    pins[7] <= 1'b0;
    repeat (8) @(posedge clock);
    pins_fall[7] <= 1'b1;
    @(posedge clock) pins[7] <= 1'b1;
    repeat (3) @(posedge clock);
    pins[7] <= 1'b0;
    repeat (8) @(posedge clock);
    #1;
    check(ivpm_entry_t'(49'd2), ivpm_entry_t'(49'(ev7_cnt)));
    idle_check(3);
    stop_test();
  end

  // Hang guard: the whole run needs a few hundred cycles
  initial begin
    #200000;
    err_total++;
    stop_test();
  end
endmodule : testbench
`default_nettype wire

//--- verilog/ivpm_core.sv
// Interrupt vector and priority map: pending flags, arbitration, core hand-off
`timescale 1ns/1ps
`default_nettype none
module ivpm_core
  import ivpm_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  // Resets from the watchdogs' internal paths, one-cycle pulses
  input wire logic wdog_a_reset_req,
  input wire logic wdog_b_reset_req,
  // Watchdog overflows and mode selects
  input wire logic wdog_a_overflow,
  input wire logic wdog_a_nmi_mode,
  input wire logic wdog_b_overflow,
  input wire logic wdog_b_nmi_mode,
  // Pins
  input wire logic nmi_pin,
  input wire logic [IVPM_NUM_EXT_PINS-1:0] ext_edge_pin,
  input wire logic [IVPM_NUM_EXT_PINS-1:0] ext_edge_fall,
  // Core-side exceptions, one-cycle pulses
  input wire logic soft_trap_req,
  input wire logic [4:0] soft_trap_num,
  input wire logic illegal_opcode_trap,
  input wire logic debug_trap,
  // Peripheral events, one-cycle pulses
  input wire logic [3:0] timer16_match_req,
  input wire logic [1:0] timer8_match_req,
  input wire logic [1:0] csi_done_req,
  input wire logic uart_a_rx_error_req,
  input wire logic uart_a_rx_done_req,
  input wire logic uart_a_tx_done_req,
  // Per-source interrupt control and core state
  input wire ivpm_int_ctrl_t [IVPM_NUM_MASKABLE-1:0] src_int_ctrl,
  input wire logic int_enable,
  input wire logic [3:0] cpu_level,
  // Core entry hand-off
  output logic entry_req,
  output ivpm_entry_t entry,
  input wire logic entry_ack,
  // Valid edge on the eighth pin, served further on
  output logic ext_edge_7_event
);

  // --------------------------------------------------------------------------
  // Reset release
  // --------------------------------------------------------------------------
  logic rst_s1_q; // First stage, read only by the second
  logic rst_sync_b; // Released copy used everywhere

  // Assert at once, release after two clean edges
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_q <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_sync_b <= rst_s1_q;
    end
  end

  // --------------------------------------------------------------------------
  // Pin synchronisers and edge detection
  // --------------------------------------------------------------------------
  localparam int NP = IVPM_NUM_EXT_PINS + 1; // Edge pins plus the NMI pin
  logic [NP-1:0] pin_s1_q; // First stage
  logic [NP-1:0] pin_s2_q; // Second stage, safe to read
  logic [NP-1:0] pin_prev_q; // Previous safe sample
  logic [NP-1:0] pin_fall; // Edge direction per pin
  logic [NP-1:0] pin_edge; // Valid edge this cycle
  logic [2:0] pin_fill_q; // Ones shift in as real samples fill the pipeline

  // Two flops per pin before any logic looks at it
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      pin_prev_q <= '0;
      pin_fill_q <= 3'h0;
    end else begin
      pin_s1_q <= {nmi_pin, ext_edge_pin};
      pin_s2_q <= pin_s1_q;
      pin_prev_q <= pin_s2_q;
      pin_fill_q <= {pin_fill_q[1:0], 1'b1};
    end
  end

  // NMI pin is rising-edge only; the others follow their direction select
  assign pin_fall = {1'b0, ext_edge_fall};
  // Edges wait until the pipeline holds real samples, so a pin idling high
  // does not look like a rising edge just after reset
  assign pin_edge = {NP{pin_fill_q[2]}}
                    & ((pin_s2_q & ~pin_prev_q & ~pin_fall) | (~pin_s2_q & pin_prev_q & pin_fall));

  // Eighth pin leaves as a registered pulse for the upper source range
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ext_edge_7_event <= 1'b0;
    end else begin
      ext_edge_7_event <= pin_edge[7];
    end
  end

  // --------------------------------------------------------------------------
  // Offer state
  // --------------------------------------------------------------------------
  ivpm_state_t state_q;
  ivpm_kind_t kind_q; // Class of the offered source
  logic [IVPM_IDX_W-1:0] idx_q; // Maskable index being offered
  logic taken; // Core accepts the offer this cycle

  assign entry_req = (state_q == IVPM_S_OFFER);
  assign taken = entry_req && entry_ack;

  // --------------------------------------------------------------------------
  // Pending flags
  // --------------------------------------------------------------------------
  logic reset_pend_q; // Reset entry owed
  logic nmi_pin_pend_q;
  logic wdog_a_nonmaskable_req; // Watchdog A non-maskable pending
  logic wdog_b_nonmaskable_req; // Watchdog B non-maskable pending
  logic exc_pend_q; // Illegal opcode or debug trap
  logic trap_pend_q; // Software trap
  logic [4:0] trap_num_q; // Bit 4 picks the high group
  logic [IVPM_NUM_MASKABLE-1:0] mask_pend_q;
  logic [IVPM_NUM_MASKABLE-1:0] mask_set;
  logic [IVPM_NUM_MASKABLE-1:0] mask_clr;
  logic wdog_a_interval_req; // Interval-mode overflow
  logic soft_trap_group_low;
  logic soft_trap_group_high;

  assign wdog_a_interval_req = wdog_a_overflow && !wdog_a_nmi_mode;
  assign soft_trap_group_low = soft_trap_req && !soft_trap_num[4];
  assign soft_trap_group_high = soft_trap_req && soft_trap_num[4];

  // Maskable events by default priority: watchdog, pins 0-6, timers, serial
  assign mask_set = {uart_a_tx_done_req, uart_a_rx_done_req, uart_a_rx_error_req,
                     csi_done_req,
                     timer8_match_req,
                     timer16_match_req,
                     pin_edge[6:0],
                     wdog_a_interval_req};

  // Only the source just taken is cleared
  always_comb begin
    mask_clr = '0;
    if (taken && kind_q == IVPM_K_MASK) begin
      mask_clr[idx_q] = 1'b1;
    end
  end

  // Maskable flags: a new event beats the clear of the same cycle
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      mask_pend_q <= '0;
    end else begin
      mask_pend_q <= (mask_pend_q & ~mask_clr) | mask_set;
    end
  end

  // Non-maskable and reset flags, set winning over clear
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      reset_pend_q <= IVPM_RESET_PEND_INIT;
      nmi_pin_pend_q <= 1'b0;
      wdog_a_nonmaskable_req <= 1'b0;
      wdog_b_nonmaskable_req <= 1'b0;
    end else begin
      reset_pend_q <= (reset_pend_q && !(taken && kind_q == IVPM_K_RESET))
                      || wdog_a_reset_req || wdog_b_reset_req;
      nmi_pin_pend_q <= (nmi_pin_pend_q && !(taken && kind_q == IVPM_K_NMI_PIN)) || pin_edge[8];
      wdog_a_nonmaskable_req <= (wdog_a_nonmaskable_req && !(taken && kind_q == IVPM_K_WDOG_A))
                                || (wdog_a_overflow && wdog_a_nmi_mode);
      wdog_b_nonmaskable_req <= (wdog_b_nonmaskable_req && !(taken && kind_q == IVPM_K_WDOG_B))
                                || (wdog_b_overflow && wdog_b_nmi_mode);
    end
  end

  // Core exceptions; a second trap before entry overwrites the number
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      exc_pend_q <= 1'b0;
      trap_pend_q <= 1'b0;
      trap_num_q <= 5'h00;
    end else begin
      exc_pend_q <= (exc_pend_q && !(taken && kind_q == IVPM_K_EXC)) || illegal_opcode_trap || debug_trap;
      trap_pend_q <= (trap_pend_q && !(taken && kind_q == IVPM_K_TRAP)) || soft_trap_req;
      if (soft_trap_req) begin
        trap_num_q <= soft_trap_num;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Arbitration
  // --------------------------------------------------------------------------
  logic mask_any; // An eligible maskable source exists
  logic [IVPM_IDX_W-1:0] mask_idx; // Its index

  ivpm_select #(
    .NUM_SRC(IVPM_NUM_MASKABLE)
  ) u_select (
    .pend(mask_pend_q & ~mask_clr),
    .ctrl(src_int_ctrl),
    .cpu_level(cpu_level),
    .any(mask_any),
    .idx(mask_idx)
  );

  ivpm_kind_t kind_d; // Winner class
  logic win_any; // Something to offer
  ivpm_entry_t entry_d; // Winner's code and handler

  // Fixed order: reset, NMI pin, watchdogs, core exceptions, then maskable
  always_comb begin
    win_any = 1'b1;
    kind_d = IVPM_K_MASK;
    entry_d = '0;
    if (reset_pend_q) begin
      kind_d = IVPM_K_RESET;
      entry_d = '{code: IVPM_CODE_RESET, handler: {16'h0000, IVPM_CODE_RESET}, save_next: 1'b0};
    end else if (nmi_pin_pend_q) begin
      kind_d = IVPM_K_NMI_PIN;
      entry_d = '{code: IVPM_CODE_NMI_PIN, handler: {16'h0000, IVPM_CODE_NMI_PIN}, save_next: 1'b1};
    end else if (wdog_a_nonmaskable_req) begin
      kind_d = IVPM_K_WDOG_A;
      entry_d = '{code: IVPM_CODE_WDOG_A_NMI, handler: {16'h0000, IVPM_CODE_WDOG_A_NMI}, save_next: 1'b1};
    end else if (wdog_b_nonmaskable_req) begin
      kind_d = IVPM_K_WDOG_B;
      entry_d = '{code: IVPM_CODE_WDOG_B_NMI, handler: {16'h0000, IVPM_CODE_WDOG_B_NMI}, save_next: 1'b1};
    end else if (exc_pend_q) begin
      kind_d = IVPM_K_EXC;
      entry_d = '{code: IVPM_CODE_EXC_TRAP, handler: {16'h0000, IVPM_CODE_EXC_TRAP}, save_next: 1'b1};
    end else if (trap_pend_q && !trap_num_q[4]) begin
      kind_d = IVPM_K_TRAP;
      entry_d = '{code: IVPM_CODE_TRAP_LOW | {12'h000, trap_num_q[3:0]},
                  handler: IVPM_HANDLER_TRAP_LOW, save_next: 1'b1};
    end else if (trap_pend_q) begin
      kind_d = IVPM_K_TRAP;
      entry_d = '{code: IVPM_CODE_TRAP_HIGH | {12'h000, trap_num_q[3:0]},
                  handler: IVPM_HANDLER_TRAP_HIGH, save_next: 1'b1};
    end else if (mask_any && int_enable) begin
      entry_d = '{code: ivpm_mask_code(mask_idx), handler: {16'h0000, ivpm_mask_code(mask_idx)},
                  save_next: 1'b1};
    end else begin
      win_any = 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Offer to the core
  // --------------------------------------------------------------------------
  // The offer is frozen until acknowledged; a later, more urgent source
  // waits, which keeps the core from seeing a vector change under it
  always_ff @(posedge clock or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state_q <= IVPM_S_IDLE;
      kind_q <= IVPM_K_RESET;
      idx_q <= '0;
      entry <= '0;
    end else begin
      unique case (state_q)
        IVPM_S_IDLE: begin
          if (win_any) begin
            state_q <= IVPM_S_OFFER;
            kind_q <= kind_d;
            idx_q <= mask_idx;
            entry <= entry_d;
          end
        end
        IVPM_S_OFFER: begin
          if (entry_ack) begin
            state_q <= IVPM_S_IDLE;
          end
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  a_reset_vector_zero: assert property (@(posedge clock) disable iff (!rst_sync_b)
    entry_req && kind_q == IVPM_K_RESET |-> entry.code == 16'h0000 && entry.handler == 32'h0 && !entry.save_next)
    else $error("reset entry not at zero");

  a_nmi_pin_entry: assert property (@(posedge clock) disable iff (!rst_sync_b)
    pin_edge[8] && state_q == IVPM_S_IDLE && !win_any && !wdog_a_reset_req && !wdog_b_reset_req
    |=> ##1 entry_req && entry.code == 16'h0010 && entry.handler == 32'h10 && entry.save_next)
    else $error("pin non-maskable entry wrong or late");

  a_wdog_a_nmi: assert property (@(posedge clock) disable iff (!rst_sync_b)
    entry_req && kind_q == IVPM_K_WDOG_A |-> entry.code == 16'h0020 && entry.handler == 32'h20)
    else $error("watchdog A non-maskable vector wrong");

  a_wdog_b_nmi: assert property (@(posedge clock) disable iff (!rst_sync_b)
    wdog_b_overflow && wdog_b_nmi_mode |=> wdog_b_nonmaskable_req)
    else $error("watchdog B non-maskable request lost");

  a_trap_low_group: assert property (@(posedge clock) disable iff (!rst_sync_b)
    entry_req && kind_q == IVPM_K_TRAP && entry.handler == 32'h40 |-> entry.code[15:4] == 12'h004)
    else $error("low trap group code wrong");

  a_trap_high_group: assert property (@(posedge clock) disable iff (!rst_sync_b)
    soft_trap_group_high && state_q == IVPM_S_IDLE && !win_any && !wdog_a_reset_req && !wdog_b_reset_req
    && !pin_edge[8] && !(wdog_a_overflow && wdog_a_nmi_mode) && !(wdog_b_overflow && wdog_b_nmi_mode)
    && !illegal_opcode_trap && !debug_trap
    |=> ##1 entry_req && entry.handler == 32'h50 && entry.code == {12'h005, $past(soft_trap_num[3:0], 2)})
    else $error("high trap group entry wrong");

  a_wdog_interval_pend: assert property (@(posedge clock) disable iff (!rst_sync_b)
    wdog_a_overflow && !wdog_a_nmi_mode && !wdog_a_nonmaskable_req |=> mask_pend_q[0] && !wdog_a_nonmaskable_req)
    else $error("interval overflow not pending at priority 0");

  a_ext_edge_pend: assert property (@(posedge clock) disable iff (!rst_sync_b)
    pin_edge[0] |=> mask_pend_q[1])
    else $error("first edge pin not pending at priority 1");

  a_mask_handler_code: assert property (@(posedge clock) disable iff (!rst_sync_b)
    entry_req && kind_q == IVPM_K_MASK
    |-> entry.handler == {16'h0000, entry.code} && entry.code == 16'h0080 + {7'h00, idx_q, 4'h0}
        && entry.code <= 16'h01a0)
    else $error("maskable code or handler wrong");

  a_offer_held: assert property (@(posedge clock) disable iff (!rst_sync_b)
    entry_req && !entry_ack |=> entry_req && $stable(entry.code) && $stable(entry.handler))
    else $error("offer changed before acknowledge");

endmodule : ivpm_core
`default_nettype wire

//--- verilog/ivpm_pkg.sv
// Package of constants and types for the interrupt vector and priority map
// ----------------------------------------------------------------------------
// Functional notes
// - Any reset vectors to address zero, code zero
// - External non-maskable edge vectors to 0x10
// - Watchdog A non-maskable overflow vectors to 0x20
// - Watchdog B non-maskable overflow vectors to 0x30
// - Low trap group shares 0x40, code 0x4n
// - High trap group shares 0x50, code 0x5n
// - Two internal non-maskable sources plus pin
// - Watchdog A interval overflow: priority 0, 0x80
// - Eight edge inputs; seven take priorities 1-7
// - Maskable handler equals code, individually gated
// - Sixteen-bit timer matches take priorities 8-11
// - Serial and first UART events take 14-18
// ----------------------------------------------------------------------------
package ivpm_pkg;

  // --------------------------------------------------------------------------
  // Source counts
  // --------------------------------------------------------------------------
  localparam int IVPM_NUM_MASKABLE = 19; // Default priorities 0..18
  localparam int IVPM_NUM_EXT_PINS = 8; // Edge-detected request pins
  localparam int IVPM_IDX_W = 5; // Width of a maskable index
  localparam int IVPM_LEVEL_W = 3; // Programmed priority level width

  // --------------------------------------------------------------------------
  // Exception codes and handler addresses
  // --------------------------------------------------------------------------
  localparam logic [15:0] IVPM_CODE_RESET = 16'h0000;
  localparam logic [15:0] IVPM_CODE_NMI_PIN = 16'h0010;
  localparam logic [15:0] IVPM_CODE_WDOG_A_NMI = 16'h0020;
  localparam logic [15:0] IVPM_CODE_WDOG_B_NMI = 16'h0030;
  localparam logic [15:0] IVPM_CODE_TRAP_LOW = 16'h0040; // Low nibble is trap number
  localparam logic [15:0] IVPM_CODE_TRAP_HIGH = 16'h0050;
  localparam logic [15:0] IVPM_CODE_EXC_TRAP = 16'h0060;
  localparam logic [15:0] IVPM_CODE_MASK_BASE = 16'h0080; // Default priority 0
  localparam logic [15:0] IVPM_CODE_STEP = 16'h0010; // Spacing of maskable codes
  localparam logic [31:0] IVPM_HANDLER_TRAP_LOW = 32'h0000_0040;
  localparam logic [31:0] IVPM_HANDLER_TRAP_HIGH = 32'h0000_0050;

  // --------------------------------------------------------------------------
  // Reset values
  // --------------------------------------------------------------------------
  localparam logic IVPM_RESET_PEND_INIT = 1'b1; // Reset entry is offered first
  localparam logic [3:0] IVPM_LEVEL_NONE = 4'h8; // Core servicing nothing

  // Programmed control of one maskable source
  typedef struct packed {
    logic mask; // 1 blocks the source
    logic [IVPM_LEVEL_W-1:0] level; // 0 is most urgent
  } ivpm_int_ctrl_t;

  // What is offered to the core
  typedef struct packed {
    logic [15:0] code;
    logic [31:0] handler;
    logic save_next; // 1: following_instr_addr is the return point
  } ivpm_entry_t;

  // Class of the offered source, one-hot
  typedef enum logic [6:0] {
    IVPM_K_RESET = 7'h01,
    IVPM_K_NMI_PIN = 7'h02,
    IVPM_K_WDOG_A = 7'h04,
    IVPM_K_WDOG_B = 7'h08,
    IVPM_K_EXC = 7'h10,
    IVPM_K_TRAP = 7'h20,
    IVPM_K_MASK = 7'h40
  } ivpm_kind_t;

  // Offer state, one-hot
  typedef enum logic [1:0] {
    IVPM_S_IDLE = 2'h1,
    IVPM_S_OFFER = 2'h2
  } ivpm_state_t;

  // Exception code of a maskable source; its handler is the code widened
  function automatic logic [15:0] ivpm_mask_code(input logic [IVPM_IDX_W-1:0] idx);
    ivpm_mask_code = IVPM_CODE_MASK_BASE + {7'h00, idx, 4'h0};
  endfunction : ivpm_mask_code

endpackage : ivpm_pkg

//--- verilog/ivpm_select.sv
// Maskable request arbiter: most urgent eligible source
`timescale 1ns/1ps
`default_nettype none
module ivpm_select
  import ivpm_pkg::*;
#(
  parameter int NUM_SRC = IVPM_NUM_MASKABLE
) (
  input wire logic [NUM_SRC-1:0] pend,
  input wire ivpm_int_ctrl_t [NUM_SRC-1:0] ctrl,
  input wire logic [3:0] cpu_level,
  output logic any,
  output logic [IVPM_IDX_W-1:0] idx
);

  // --------------------------------------------------------------------------
  // Linear scan
  // --------------------------------------------------------------------------
  // Ascending scan with a strict comparison keeps the lowest index on a tie
  always_comb begin
    logic [3:0] best;
    best = cpu_level;
    any = 1'b0;
    idx = '0;
    for (int i = 0; i < NUM_SRC; i++) begin
      // Unmasked and more urgent than both the core and any earlier pick
      if (pend[i] && !ctrl[i].mask && ({1'b0, ctrl[i].level} < best)) begin
        best = {1'b0, ctrl[i].level};
        any = 1'b1;
        idx = IVPM_IDX_W'(i);
      end
    end
    // A granted source never beats a lower index at the same level;
    // checked in the same process so it never sees a stale pick
    for (int j = 0; j < NUM_SRC; j++) begin
      if (any && (IVPM_IDX_W'(j) < idx) && pend[j] && !ctrl[j].mask) begin
        a_tie_lowest_wins: assert (ctrl[j].level > ctrl[idx].level)
          else $error("lower index at equal level was passed over");
      end
    end
  end

endmodule : ivpm_select
`default_nettype wire
